// ---- shared/wtsfe_pkg.sv ----
// Shared constants and helpers for the slot frame engine
package wtsfe_pkg;
	// Frame and slot timing
	localparam int SLOT_CYCLES   = 68;
	localparam int SLOTS_MIN     = 16;
	localparam int SLOTS_MAX     = 32;
	localparam int CYC_SAMPLE0   = 8;
	localparam int CYC_SAMPLE1   = 16;
	localparam int CYC_MIX       = 66;
	localparam int CYC_LAST      = SLOT_CYCLES - 1;
	// Parameter memory geometry
	localparam int PRAM_WORDS    = 512;
	localparam int PRAM_WIDTH    = 19;
	localparam int PRAM_BLOCK    = 16;
	// Word indexes inside a slot block
	localparam logic [3:0] W_PITCH  = 4'h0;
	localparam logic [3:0] W_FRAC   = 4'h1;
	localparam logic [3:0] W_WAVE   = 4'h2;
	localparam logic [3:0] W_ENDW   = 4'h3;
	localparam logic [3:0] W_LOOPW  = 4'h4;
	localparam logic [3:0] W_ENVLVL = 4'h5;
	localparam logic [3:0] W_ENVSEG = 4'h6;
	localparam logic [3:0] W_COMMON = 4'hF;
	// Common word fields
	localparam int C_LEVEL       = 4;
	localparam int C_PAN         = 8;
	localparam int C_PAIR        = 12;
	localparam int C_PHASE       = 13;
	localparam int C_BUSY        = 18;
	localparam logic [3:0] ALGO_REFRESH = 4'h0;
	localparam logic [3:0] ALGO_HQ      = 4'h1;
	// Wave and envelope fields
	localparam int E_LOOPLAST    = 9;
	localparam int E_PAGE        = 10;
	localparam int ENV_RATE      = 12;
	localparam logic [2:0] ENV_AMP = 3'h0;
	// Configuration register bits
	localparam int CFG_RUN       = 0;
	localparam int CFG_DC_OFFSET_SELECT      = 1;
	localparam int CFG_IE        = 2;
	localparam int CFG_SERIAL_IDLE_FORMAT      = 3;
	localparam int CFG_SLOTS     = 4;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// Host bus addresses and data bits
	localparam logic [1:0] A_ADDR = 2'h0;
	localparam logic [1:0] A_LOW  = 2'h1;
	localparam logic [1:0] A_MID  = 2'h2;
	localparam logic [1:0] A_HIGH = 2'h3;
	localparam int D_CFG         = 6;
	localparam int D_PAGE        = 7;
	// Output stage
	localparam logic [19:0] DC_OFFSET = 20'h06666;
	localparam int SER_BIT_CYCLES = 17;
	localparam int SER_WORD_BITS  = 20;

	// Signed 24-bit add that clamps instead of wrapping
	function automatic logic [23:0] sat_add24(logic [23:0] a,
		logic [23:0] b);
		logic [24:0] s;
		s = {a[23], a} + {b[23], b};
		if (s[24] != s[23])
			sat_add24 = s[24] ? 24'h800000 : 24'h7FFFFF;
		else
			sat_add24 = s[23:0];
	endfunction
endpackage

// ---- hw/wtsfe_wave_step.sv ----
// Phase accumulation and wave loop step for one playback slot
`timescale 1ns/1ps
module wtsfe_wave_step
	import wtsfe_pkg::*;
(
	input  wire logic [17:0] pitch,
	input  wire logic [11:0] fracIn,
	input  wire logic [16:0] posIn,
	input  wire logic [8:0]  endWave,
	input  wire logic [8:0]  loopWave,
	input  wire logic        loopLast,
	output logic      [11:0] fracOut,
	output logic      [16:0] posOut
);
	// Wave, integer phase and fraction added as one number
	logic [29:0] sum;
	logic [8:0]  cwNext;
	logic        passEnd;
	assign sum     = {1'b0, posIn, fracIn} + {12'h000, pitch};
	assign cwNext  = sum[28:20];
	assign passEnd = (posIn[16:8] == endWave) && (cwNext != endWave);
	assign fracOut = sum[11:0];
	// Leaving the end wave reloads loop or end wave
	assign posOut  = passEnd
		? {(loopLast ? endWave : loopWave), sum[19:12]}
		: sum[28:12];
endmodule // wtsfe_wave_step

// ---- hw/wtsfe_serializer.sv ----
// Serial output shifter for the two stereo sample lines
`timescale 1ns/1ps
module wtsfe_serializer
	import wtsfe_pkg::*;
#(
	parameter int BIT_CYCLES = SER_BIT_CYCLES,
	parameter int WORD_BITS  = SER_WORD_BITS
)(
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	input  wire logic                 load,
	input  wire logic                 idleMsb,
	input  wire logic [WORD_BITS-1:0] wordAL,
	input  wire logic [WORD_BITS-1:0] wordAR,
	input  wire logic [WORD_BITS-1:0] wordBL,
	input  wire logic [WORD_BITS-1:0] wordBR,
	output logic                      serBitClk,
	output logic                      serWordSel,
	output logic                      audioSerialOutA,
	output logic                      audioSerialOutB
);
	localparam int FB = 2 * WORD_BITS;
	localparam int DW = $clog2(BIT_CYCLES);
	localparam int LW = $clog2(FB + 1);

	logic [FB-1:0] shA_q;
	logic [FB-1:0] shB_q;
	logic [DW-1:0] div_q;
	logic [LW-1:0] left_q;
	logic          wordSel_q;
	logic          step;

	// Bit order: MSB first idles on LSB, LSB first idles on MSB
	function automatic logic [WORD_BITS-1:0] ord(
		logic [WORD_BITS-1:0] w, logic rev);
		logic [WORD_BITS-1:0] r;
		r = w;
		for (int k = 0; k < WORD_BITS; k++)
			if (rev)
				r[k] = w[WORD_BITS-1-k];
		return r;
	endfunction

	assign step       = (left_q != '0) && (div_q == '0);
	assign serBitClk  = (div_q >= DW'(BIT_CYCLES / 2));
	assign serWordSel = wordSel_q;

	// Shift one bit per bit period, hold the last bit when done
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			shA_q <= '0;
			shB_q <= '0;
			div_q <= '0;
			left_q <= '0;
			wordSel_q <= 1'b0;
			audioSerialOutA <= 1'b0;
			audioSerialOutB <= 1'b0;
		end
		else if (load)
		begin
			shA_q <= {ord(wordAL, idleMsb), ord(wordAR, idleMsb)};
			shB_q <= {ord(wordBL, idleMsb), ord(wordBR, idleMsb)};
			div_q <= '0;
			left_q <= LW'(FB);
		end
		else
		begin
			if (left_q != '0 || div_q != '0)
				div_q <= (div_q == DW'(BIT_CYCLES - 1)) ? '0 : div_q + 1'b1;
			if (step)
			begin
				audioSerialOutA <= shA_q[FB-1];
				audioSerialOutB <= shB_q[FB-1];
				shA_q <= shA_q << 1;
				shB_q <= shB_q << 1;
				left_q <= left_q - 1'b1;
				wordSel_q <= (left_q > LW'(WORD_BITS));
			end
		end
	end

	AST_SER_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
		(left_q == '0 && $past(left_q) == '0 && !load && !$past(load))
		|-> $stable(audioSerialOutA) && $stable(audioSerialOutB))
		else $error("serial line moved while idle");
endmodule // wtsfe_serializer

// ---- hw/wtsfe_engine.sv ----
// Slot frame synthesis engine with host bus, mixer and outputs
//
// Behaviour
// - Slots per frame programmable, any even count from 16 to 32.
// - Every slot lasts 68 clocks and runs one algorithm.
// - Frame is N slots; one stereo sample set per frame.
// - Parameter memory 512 x 19, 32 blocks of 16 words.
// - Last block word picks the algorithm; others per algorithm.
// - Slot output scaled by mix fields into four 24-bit accumulators.
// - Accumulators cannot overflow while summing slot outputs.
// - At frame end accumulators go as 20-bit words to two 40-bit shifters, then clear.
// - Shift registers send sample words out serially.
// - Sample memory is 64 pages of 512 waves of 256 samples.
// - Wave pointer advances to end wave, then reloads loop wave.
// - Loop-last mode keeps repeating the end wave.
// - Pitch 18 bits: upper 6 integer, lower 12 fractional.
// - Playback rate is pitch over 4096 samples per frame.
// - High-quality algorithm interpolates by the fractional phase.
// - Linear envelope segments; endpoint reached raises an interrupt.
// - Host bus: two address, eight data, chip select, write, read.
// - Configuration register is 8 bits and write-only.
// - Run bit 0 (reset) forces every slot idle.
// - Offset bit 1 adds five percent positive DC offset.
// - Envelope interrupt enable bit 0 (reset) masks interrupts.
// - Serial format 0 idles on LSB, 1 idles on MSB.
// - Read-only interrupt register holds slot and envelope number.
// - Word 15 holds algorithm, mix, phase constant and busy flag.
`timescale 1ns/1ps
module wtsfe_engine
	import wtsfe_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [1:0]  hostAddr,
	input  wire logic [7:0]  hostDataIn,
	output logic      [7:0]  hostDataOut,
	output logic             hostDataOe,
	input  wire logic        hostCsN,
	input  wire logic        hostWrN,
	input  wire logic        hostRdN,
	output logic             irqN,
	output logic      [22:0] waveAddr,
	input  wire logic [11:0] sampleIn,
	output logic             serBitClk,
	output logic             serWordSel,
	output logic             audioSerialOutA,
	output logic             audioSerialOutB
);
	// Parameter memory, one 16-word block per slot
	logic [PRAM_WIDTH-1:0] pram [PRAM_WORDS];

	// Host interface state
	logic       wrNPrev_q;
	logic       rdNPrev_q;
	logic [1:0] addrLat_q;
	logic [7:0] dataLat_q;
	logic       cfgMode_q;
	logic       readArm_q;
	logic       page_q;
	logic [7:0] pramAddr_q;
	logic [7:0] lowByte_q;
	logic [7:0] midByte_q;
	logic [18:0] rdWord_q;
	logic [7:0] cfg_q;
	logic [7:0] hostDataOut_q;
	logic [7:0] irqReg_q;
	logic       irqPend_q;

	// Latch address and data while the write strobe is low
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wrNPrev_q <= 1'b1;
			rdNPrev_q <= 1'b1;
			addrLat_q <= '0;
			dataLat_q <= '0;
		end
		else
		begin
			wrNPrev_q <= hostWrN;
			rdNPrev_q <= hostRdN;
			if (!hostWrN)
			begin
				addrLat_q <= hostAddr;
				dataLat_q <= hostDataIn;
			end
		end
	end

	// Host access decode on the trailing strobe edge
	logic wrDone, rdDone, wrCfgEnter, wrCfgLoad, wrAddr, wrRead;
	logic wrPram, rdIrq, rdDummy;
	assign wrDone     = !hostCsN && hostWrN && !wrNPrev_q;
	assign rdDone     = !hostCsN && hostRdN && !rdNPrev_q;
	assign wrCfgEnter = wrDone && addrLat_q == A_HIGH && dataLat_q[D_CFG];
	assign wrCfgLoad  = wrDone && addrLat_q == A_ADDR && cfgMode_q;
	assign wrAddr     = wrDone && addrLat_q == A_ADDR && !cfgMode_q;
	assign wrRead     = wrAddr && readArm_q;
	assign wrPram     = wrDone && addrLat_q == A_HIGH && !dataLat_q[D_CFG];
	assign rdIrq      = rdDone && hostAddr == A_ADDR;
	assign rdDummy    = rdDone && hostAddr == A_LOW && cfgMode_q;

	// Configuration mode, page, address and data byte registers
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cfgMode_q <= 1'b0;
			readArm_q <= 1'b0;
			page_q <= 1'b0;
			pramAddr_q <= '0;
			lowByte_q <= '0;
			midByte_q <= '0;
			cfg_q <= CFG_RESET;
		end
		else
		begin
			if (wrCfgEnter)
				cfgMode_q <= 1'b1;
			else if (wrCfgLoad || rdDummy)
				cfgMode_q <= 1'b0;
			if (rdDummy)
				readArm_q <= 1'b1;
			else if (wrAddr)
				readArm_q <= 1'b0;
			if (wrDone && addrLat_q == A_HIGH)
				page_q <= dataLat_q[D_PAGE];
			if (wrAddr)
				pramAddr_q <= dataLat_q;
			if (wrDone && addrLat_q == A_LOW)
				lowByte_q <= dataLat_q;
			if (wrDone && addrLat_q == A_MID)
				midByte_q <= dataLat_q;
			if (wrCfgLoad)
				cfg_q <= dataLat_q;
		end
	end

	// Read data: interrupt register or parameter word bytes
	logic [7:0] rdSel;
	assign rdSel = (hostAddr == A_ADDR) ? irqReg_q
		: (hostAddr == A_LOW) ? rdWord_q[7:0]
		: (hostAddr == A_MID) ? rdWord_q[15:8]
		: {5'h00, rdWord_q[18:16]};
	assign hostDataOe  = !hostCsN && !hostRdN;
	assign hostDataOut = hostDataOut_q;

	// Slot and cycle counters
	logic [6:0] cyc_q;
	logic [4:0] slot_q;
	logic [5:0] slotCount;
	logic       slotEnd, frameEnd;
	assign slotCount = cfg_q[CFG_SLOTS+3] ? 6'(SLOTS_MIN)
		: 6'(SLOTS_MIN + 2) + {2'b00, cfg_q[CFG_SLOTS+2:CFG_SLOTS], 1'b0};
	assign slotEnd  = (cyc_q == 7'(CYC_LAST));
	assign frameEnd = slotEnd && ({1'b0, slot_q} >= slotCount - 6'h01);

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cyc_q <= '0;
			slot_q <= '0;
		end
		else
		begin
			cyc_q <= slotEnd ? '0 : cyc_q + 7'h01;
			if (frameEnd)
				slot_q <= '0;
			else if (slotEnd)
				slot_q <= slot_q + 5'h01;
		end
	end

	// Words of the running slot's block
	logic [18:0] common, wPitch, wFrac, wWave, wEnd, wLoop, wLvl, wSeg;
	assign common = pram[{slot_q, W_COMMON}];
	assign wPitch = pram[{slot_q, W_PITCH}];
	assign wFrac  = pram[{slot_q, W_FRAC}];
	assign wWave  = pram[{slot_q, W_WAVE}];
	assign wEnd   = pram[{slot_q, W_ENDW}];
	assign wLoop  = pram[{slot_q, W_LOOPW}];
	assign wLvl   = pram[{slot_q, W_ENVLVL}];
	assign wSeg   = pram[{slot_q, W_ENVSEG}];

	logic [3:0] algo;
	logic       slotActive, mixNow;
	assign algo       = common[3:0];
	assign slotActive = cfg_q[CFG_RUN] && common[C_BUSY]
		&& algo != ALGO_REFRESH;
	assign mixNow     = slotActive && cyc_q == 7'(CYC_MIX);

	// Phase step and wave looping for this slot
	logic [11:0] fracNext;
	logic [16:0] posNext;
	wtsfe_wave_step u_wave (
		.pitch    (wPitch[17:0]),
		.fracIn   (wFrac[11:0]),
		.posIn    (wWave[16:0]),
		.endWave  (wEnd[8:0]),
		.loopWave (wLoop[8:0]),
		.loopLast (wEnd[E_LOOPLAST]),
		.fracOut  (fracNext),
		.posOut   (posNext)
	);

	// Sample fetch: page, wave, integer phase address
	logic [22:0] waveAddr_q;
	logic [11:0] s0_q, s1_q;
	assign waveAddr = waveAddr_q;
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			waveAddr_q <= '0;
			s0_q <= '0;
			s1_q <= '0;
		end
		else if (cyc_q == 7'h00)
			waveAddr_q <= {wEnd[E_PAGE+5:E_PAGE], wWave[16:0]};
		else if (cyc_q == 7'(CYC_SAMPLE0))
		begin
			s0_q <= sampleIn;
			waveAddr_q <= {wEnd[E_PAGE+5:E_PAGE], wWave[16:0] + 17'h00001};
		end
		else if (cyc_q == 7'(CYC_SAMPLE1))
			s1_q <= sampleIn;
	end

	// Voice: interpolation, envelope and level/pan scaling
	logic signed [12:0] diff, interp, voice;
	logic signed [25:0] lerp, amp;
	logic [7:0]         gainL, gainR;
	logic signed [32:0] mixL, mixR;
	assign diff   = $signed({s1_q[11], s1_q}) - $signed({s0_q[11], s0_q});
	assign lerp   = diff * $signed({1'b0, wFrac[11:0]});
	assign interp = $signed({s0_q[11], s0_q}) + lerp[24:12];
	assign voice  = (algo == ALGO_HQ) ? interp : $signed({s0_q[11], s0_q});
	assign amp    = voice * $signed({1'b0, wLvl[11:0]});
	assign gainL  = common[C_LEVEL+3:C_LEVEL]
		* (4'hF - common[C_PAN+3:C_PAN]);
	assign gainR  = common[C_LEVEL+3:C_LEVEL] * common[C_PAN+3:C_PAN];
	assign mixL   = $signed(amp[23:0]) * $signed({1'b0, gainL});
	assign mixR   = $signed(amp[23:0]) * $signed({1'b0, gainR});

	// Four clamping accumulators, cleared at frame end
	logic [23:0] acc_q [4];
	logic [19:0] outWord [4];
	for (genvar i = 0; i < 4; i++)
	begin : g_acc
		logic        hit;
		logic [23:0] addend;
		logic [20:0] ofsSum;
		assign hit    = mixNow && common[C_PAIR] == 1'(i / 2);
		assign addend = (i % 2 == 1) ? mixR[31:8] : mixL[31:8];
		assign ofsSum = {acc_q[i][23], acc_q[i][23:4]}
			+ {1'b0, (cfg_q[CFG_DC_OFFSET_SELECT] ? DC_OFFSET : 20'h00000)};
		assign outWord[i] = (ofsSum[20] != ofsSum[19]) ? 20'h7FFFF
			: ofsSum[19:0];
		always_ff @(posedge clock or negedge reset_n)
		begin
			if (!reset_n)
				acc_q[i] <= '0;
			else if (frameEnd)
				acc_q[i] <= '0;
			else if (hit)
				acc_q[i] <= sat_add24(acc_q[i], addend);
		end
		AST_ACC_SAT: assert property (@(posedge clock)
			disable iff (!reset_n)
			(hit && !acc_q[i][23] && !addend[23]) |=> !acc_q[i][23])
			else $error("accumulator wrapped to negative");
	end

	// Envelope segment step toward its endpoint
	logic [11:0] lvl, endp, lvlNext;
	logic [6:0]  rate;
	logic        envEvent;
	assign lvl  = wLvl[11:0];
	assign endp = wSeg[11:0];
	assign rate = wSeg[ENV_RATE+6:ENV_RATE];
	assign lvlNext = (lvl < endp)
		? ((endp - lvl <= {5'h00, rate}) ? endp : lvl + {5'h00, rate})
		: ((lvl - endp <= {5'h00, rate}) ? endp : lvl - {5'h00, rate});
	assign envEvent = mixNow && lvl != endp && lvlNext == endp;

	// Parameter memory writes; host write wins a collision
	always_ff @(posedge clock)
	begin
		if (mixNow)
		begin
			pram[{slot_q, W_FRAC}] <= {7'h00, fracNext};
			pram[{slot_q, W_WAVE}] <= {2'b00, posNext};
			pram[{slot_q, W_ENVLVL}] <= {wLvl[18:12], lvlNext};
		end
		if (wrPram)
			pram[{dataLat_q[D_PAGE], pramAddr_q}]
				<= {dataLat_q[2:0], midByte_q, lowByte_q};
	end

	// Read word fetch, interrupt register and read data
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdWord_q <= '0;
			irqPend_q <= 1'b0;
			irqReg_q <= '0;
			hostDataOut_q <= '0;
		end
		else
		begin
			if (wrRead)
				rdWord_q <= pram[{page_q, dataLat_q}];
			if (envEvent)
			begin
				irqPend_q <= 1'b1;
				irqReg_q <= {slot_q, ENV_AMP};
			end
			else if (rdIrq)
				irqPend_q <= 1'b0;
			if (!hostCsN && !hostRdN)
				hostDataOut_q <= rdSel;
		end
	end
	assign irqN = !(irqPend_q && cfg_q[CFG_IE]);

	// Serial output of the four frame words
	wtsfe_serializer u_ser (
		.clock           (clock),
		.reset_n         (reset_n),
		.load            (frameEnd),
		.idleMsb         (cfg_q[CFG_SERIAL_IDLE_FORMAT]),
		.wordAL          (outWord[0]),
		.wordAR          (outWord[1]),
		.wordBL          (outWord[2]),
		.wordBR          (outWord[3]),
		.serBitClk       (serBitClk),
		.serWordSel      (serWordSel),
		.audioSerialOutA (audioSerialOutA),
		.audioSerialOutB (audioSerialOutB)
	);

	AST_SLOT_LEN: assert property (@(posedge clock) disable iff (!reset_n)
		(cyc_q == 7'h00) |-> ##67 slotEnd)
		else $error("slot not 68 clocks long");
	AST_SLOT_RANGE: assert property (@(posedge clock) disable iff (!reset_n)
		slotCount >= 6'(SLOTS_MIN) && slotCount <= 6'(SLOTS_MAX)
		&& !slotCount[0])
		else $error("slot count out of range or odd");
	AST_FRAME_WRAP: assert property (@(posedge clock) disable iff (!reset_n)
		frameEnd |=> slot_q == 5'h00 && cyc_q == 7'h00)
		else $error("frame did not restart at slot zero");
	AST_ACC_CLEAR: assert property (@(posedge clock) disable iff (!reset_n)
		frameEnd |=> acc_q[0] == '0 && acc_q[1] == '0
			&& acc_q[2] == '0 && acc_q[3] == '0)
		else $error("accumulators not cleared at frame end");
	AST_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
		!cfg_q[CFG_RUN] |-> !mixNow && !envEvent)
		else $error("slot processed while run is off");
	AST_IRQ_MASK: assert property (@(posedge clock) disable iff (!reset_n)
		(envEvent && cfg_q[CFG_IE] && !wrCfgLoad) |=> !irqN)
		else $error("enabled envelope interrupt not raised");
	AST_CFG_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
		wrCfgLoad |=> cfg_q == $past(dataLat_q) && !cfgMode_q)
		else $error("configuration byte not taken");
	AST_LOOP_LAST: assert property (@(posedge clock) disable iff (!reset_n)
		(mixNow && wEnd[E_LOOPLAST] && wWave[16:8] == wEnd[8:0] && !wrPram)
		|=> pram[{slot_q, W_WAVE}][16:8] == $past(wEnd[8:0]))
		else $error("loop-last mode left the end wave");
endmodule // wtsfe_engine

// ---- sim/wtsfe_host_model.sv ----
// Host processor and sample memory model facing the engine
`timescale 1ns/1ps
module wtsfe_host_model
	import wtsfe_pkg::*;
(
	input  wire logic        clock,
	input  wire logic [7:0]  rdData,
	input  wire logic [22:0] waveAddr,
	input  wire logic        dataOe,
	output logic      [1:0]  hostAddr,
	output logic      [7:0]  hostDataIn,
	output logic             hostCsN,
	output logic             hostWrN,
	output logic             hostRdN,
	output logic      [11:0] sampleIn
);
	// Sample memory answers with a pattern of its address
	assign sampleIn = waveAddr[11:0] ^ waveAddr[22:11];

	// Output enable as seen when read data is taken
	logic oeSeen;

	// Bus idles deselected
	initial
	begin
		hostAddr = 2'h0;
		hostDataIn = 8'h00;
		hostCsN = 1'b1;
		hostWrN = 1'b1;
		hostRdN = 1'b1;
		oeSeen = 1'b0;
	end

	// Write cycle; access lands when the strobe rises under select
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		hostAddr = a;
		hostDataIn = d;
		hostCsN = 1'b0;
		hostWrN = 1'b0;
		repeat (2) @(negedge clock);
		hostWrN = 1'b1;
		repeat (2) @(negedge clock);
		hostCsN = 1'b1;
		hostDataIn = ~d;
		repeat (2) @(negedge clock);
	endtask

	// Read cycle; data taken before the strobe is released
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		hostAddr = a;
		hostCsN = 1'b0;
		hostRdN = 1'b0;
		repeat (2) @(negedge clock);
		d = rdData;
		oeSeen = dataOe;
		hostRdN = 1'b1;
		@(negedge clock);
		hostCsN = 1'b1;
		repeat (2) @(negedge clock);
	endtask

	// Configuration load through the mode-entry write
	task automatic cfgW(input logic [7:0] c);
		wr(A_HIGH, 8'h40);
		wr(A_ADDR, c);
	endtask

	// Parameter word write, then the settle time
	task automatic pw(input logic [4:0] s, input logic [3:0] w,
		input logic [18:0] v);
		wr(A_ADDR, {s[3:0], w});
		wr(A_LOW, v[7:0]);
		wr(A_MID, v[15:8]);
		wr(A_HIGH, {s[4], 4'h0, v[18:16]});
		repeat (SLOT_CYCLES) @(negedge clock);
	endtask

	// Parameter word read with page select and dummy read
	task automatic pr(input logic [4:0] s, input logic [3:0] w,
		output logic [18:0] v);
		logic [7:0] lo;
		logic [7:0] mi;
		logic [7:0] hi;
		wr(A_HIGH, {s[4], 1'b1, 6'h00});
		rd(A_LOW, lo);
		wr(A_ADDR, {s[3:0], w});
		repeat (SLOT_CYCLES) @(negedge clock);
		rd(A_LOW, lo);
		rd(A_MID, mi);
		rd(A_HIGH, hi);
		v = {hi[2:0], mi, lo};
	endtask
endmodule // wtsfe_host_model

// ---- sim/wtsfe_engine_tb.sv ----
// Self-checking bench for the slot frame engine
`timescale 1ns/1ps
module wtsfe_engine_tb
	import wtsfe_pkg::*;
	;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic [1:0]  hostAddr;
	logic [7:0]  hostDataIn;
	logic [7:0]  hostDataOut;
	logic        hostDataOe;
	logic        serBitClk;
	logic        hostCsN;
	logic        hostWrN;
	logic        hostRdN;
	logic        irqN;
	logic [22:0] waveAddr;
	logic [11:0] sampleIn;
	logic        serWordSel;
	logic        audioSerialOutA;
	logic        audioSerialOutB;
	int          errTotal = 0;
	int          testsRun = 0;

	// Free-running clock
	always #5 clock = ~clock;

	wtsfe_engine dut (.clock(clock), .reset_n(reset_n),
		.hostAddr(hostAddr), .hostDataIn(hostDataIn),
		.hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
		.hostCsN(hostCsN),
		.hostWrN(hostWrN), .hostRdN(hostRdN), .irqN(irqN),
		.waveAddr(waveAddr), .sampleIn(sampleIn), .serBitClk(serBitClk),
		.serWordSel(serWordSel), .audioSerialOutA(audioSerialOutA),
		.audioSerialOutB(audioSerialOutB));

	wtsfe_host_model h (.clock(clock), .rdData(hostDataOut),
		.waveAddr(waveAddr), .dataOe(hostDataOe), .hostAddr(hostAddr),
		.hostDataIn(hostDataIn), .hostCsN(hostCsN), .hostWrN(hostWrN),
		.hostRdN(hostRdN), .sampleIn(sampleIn));

	// Verdict and end of run
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Wait for the next frame start; returns cycles waited
	task automatic waitFrame(output int cyc);
		logic p;
		p = 1'b1;
		for (cyc = 1; cyc < 8000; cyc++)
		begin
			@(negedge clock);
			if (p === 1'b0 && serWordSel === 1'b1)
				return;
			p = serWordSel;
		end
		errTotal++;
		summarize();
	endtask

	// Frame length for a slot count; config not readable
	task automatic framePeriod(input logic [7:0] cfg, input int n);
		int c;
		logic [7:0] r;
		h.cfgW(cfg);
		h.rd(A_ADDR, r);
		check(r, 8'h00);
		check(h.oeSeen, 1'b1);
		waitFrame(c);
		waitFrame(c);
		check(c, SLOT_CYCLES * n);
	endtask

	// Serial words with offset and bit order choices
	task automatic serialOut(input logic [7:0] cfg);
		logic [19:0] w;
		int b;
		h.cfgW(cfg);
		w = cfg[CFG_DC_OFFSET_SELECT] ? DC_OFFSET : 20'h00000;
		waitFrame(b);
		waitFrame(b);
		check(serBitClk, 1'b0);
		repeat (8) @(negedge clock);
		for (int i = 0; i < 41; i++)
		begin
			b = (i > 39) ? 19 : i % 20;
			b = cfg[CFG_SERIAL_IDLE_FORMAT] ? b : 19 - b;
			check(audioSerialOutA, w[b]);
			check(audioSerialOutB, w[b]);
			check(serBitClk, i < 40);
			if (i < 40)
				check(serWordSel, i < 20);
			repeat (SER_BIT_CYCLES) @(negedge clock);
		end
	endtask

	// Two frames of playback on slot 3, then pointer and interrupt
	task automatic play(input logic last, input logic ie, input logic run);
		logic [18:0] v;
		logic [7:0] r;
		int c;
		h.pw(5'd3, W_COMMON, last ? 19'h40001 : 19'h40002);
		h.pw(5'd3, W_PITCH, 19'h01800);
		h.pw(5'd3, W_FRAC, 19'h00000);
		h.pw(5'd3, W_WAVE, 19'h005FF);
		h.pw(5'd3, W_ENDW, {9'h000, last, 9'h005});
		h.pw(5'd3, W_LOOPW, 19'h00002);
		h.pw(5'd3, W_ENVLVL, 19'h00010);
		h.pw(5'd3, W_ENVSEG, {7'h01, 12'h011});
		waitFrame(c);
		h.cfgW({4'h8, 1'b0, ie, 1'b0, run});
		waitFrame(c);
		waitFrame(c);
		h.cfgW({4'h8, 1'b0, ie, 2'b00});
		check(irqN, !(run && ie));
		h.rd(A_ADDR, r);
		check(r, run ? 8'h18 : 8'h00);
		check(irqN, 1'b1);
		h.pr(5'd3, W_WAVE, v);
		check(v, !run ? 19'h005FF : last ? 19'h00502 : 19'h00202);
		h.pr(5'd3, W_FRAC, v);
		check(v, 19'h00000);
	endtask

	// Main sequence
	initial
	begin
		logic [7:0] cfgs[4] = '{8'h80, 8'h70, 8'h30, 8'h00};
		int slots[4] = '{16, 32, 24, 18};
		logic [18:0] v;
		int c;
		repeat (12) @(negedge clock);
		check(irqN, 1'b1);
		check(waveAddr, 23'h0);
		check(audioSerialOutA, 1'b0);
		check(hostDataOe, 1'b0);
		reset_n = 1'b1;
		waitFrame(c);
		waitFrame(c);
		check(c, SLOT_CYCLES * 18);
		for (int i = 0; i < 4; i++)
			framePeriod(cfgs[i], slots[i]);
		serialOut(8'h82);
		serialOut(8'h8A);
		serialOut(8'h88);
		h.pw(5'd31, 4'h7, 19'h42B97);
		h.pw(5'd0, 4'h7, 19'h1D468);
		h.pr(5'd31, 4'h7, v);
		check(v, 19'h42B97);
		h.pr(5'd0, 4'h7, v);
		check(v, 19'h1D468);
		for (int s = 0; s < 32; s++)
			h.pw(s[4:0], W_COMMON, 19'h00000);
		play(1'b0, 1'b1, 1'b0);
		play(1'b0, 1'b0, 1'b1);
		play(1'b1, 1'b1, 1'b1);
		summarize();
	end
endmodule // wtsfe_engine_tb
